//--- dv/sfc_properties.sv
// concurrent checks on the wires between host and device
`timescale 1ns/10ps
module sfc_properties (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link wires
  input wire logic sclk,
  input wire logic sdin,
  input wire logic sync_n,
  input wire logic fault_o,
  input wire logic fault_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [4:0] nfall;  // falling link clock edges seen in this frame

  // count falls inside a frame; cleared while sync is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nfall <= 5'h00;
    end else if (sync_n) begin
      nfall <= 5'h00;
    end else if ($fell(sclk)) begin
      nfall <= nfall + 5'h01;
    end
  end

  a_fault_drive: assert property (fault_oe |-> !fault_o)
    else $error("fault wire driven high");
  a_bit_count: assert property ($rose(sync_n) |-> nfall == 5'd16 || nfall == 5'd24)
    else $error("frame length neither 16 nor 24");
  a_sdin_steady: assert property (!sync_n && $fell(sclk) |-> $stable(sdin))
    else $error("data moved at falling link clock");
  a_sync_idle: assert property (sync_n |-> sclk)
    else $error("link clock low outside frame");
  a_sync_start: assert property ($fell(sync_n) |-> sclk [*4] ##1 !sclk)
    else $error("first fall not one half period after sync");
  a_sclk_low: assert property ($fell(sclk) |=> !sclk [*3])
    else $error("link clock low phase too short");
  a_frame_gap: assert property ($rose(sync_n) |-> sync_n [*4])
    else $error("sync high gap too short");
  a_fault_rise: assert property ($rose(fault_oe) |-> $past(sync_n, 3))
    else $error("fault pulled inside a frame");
  a_fault_clear: assert property ($fell(fault_oe) |-> $past(sync_n, 3))
    else $error("fault released inside a frame");
endmodule // sfc_properties

//--- dv/tb.sv
// self-checking bench: host and device on one link, a raw driver on a second
`timescale 1ns/10ps
module tb;
  import sfc_pkg::*;
  // clock, reset and apb
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, last_err;
  // device pins
  logic        hw_mode = 1'b0, sense_pin = 1'b0;
  logic [3:0]  range_pins = 4'h0;
  logic [2:0]  flt = 3'h0;  // over temp, iout open, vout short
  logic [3:0]  rng1, rng2;
  logic        ovr1, sns1, clr1, oen1, fail1, done1, fail2, done2;
  // bookkeeping
  logic [8:0]  expq[$];     // noted config per frame event
  logic [8:0]  cur = 9'h000;
  logic        ev_d = 1'b0, fail_d = 1'b0;  // frame event seen one edge ago
  int          err_total = 0, checks = 0, n_fail2 = 0, n_done2 = 0;

  sfc_link_if l1();
  sfc_link_if l2();
  // open-drain fault wires with pull-ups
  assign l1.fault_i = l1.fault_oe ? l1.fault_o : 1'b1;
  assign l2.fault_i = l2.fault_oe ? l2.fault_o : 1'b1;

  sfc_host #(.HALF_CYC(4)) sfc_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .link(l1));
  sfc_dev sfc_dev_i (.pclk(pclk), .presetn(presetn), .link(l1), .hw_mode(hw_mode),
    .range_pins(range_pins), .sense_pin(sense_pin), .over_temp(flt[2]), .iout_open(flt[1]),
    .vout_short(flt[0]), .range_code(rng1), .overrange_en(ovr1), .sense_res_select(sns1),
    .clear_sel(clr1), .out_enable(oen1), .crc_fail(fail1), .frame_done(done1));
  // second device, fed by the raw driver that can break the framing rules
  sfc_dev sfc_dev_x_i (.pclk(pclk), .presetn(presetn), .link(l2), .hw_mode(hw_mode),
    .range_pins(range_pins), .sense_pin(sense_pin), .over_temp(flt[2]), .iout_open(flt[1]),
    .vout_short(flt[0]), .range_code(rng2), .overrange_en(), .sense_res_select(),
    .clear_sel(), .out_enable(), .crc_fail(fail2), .frame_done(done2));
  sfc_properties sfc_properties_i (.pclk(pclk), .presetn(presetn), .sclk(l1.sclk),
    .sdin(l1.sdin), .sync_n(l1.sync_n), .fault_o(l1.fault_o), .fault_oe(l1.fault_oe));

  always #50 pclk = ~pclk;

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) err_total++;
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  // config seen after a control word: fail, range, overrange, sense, clear, enable
  function automatic logic [8:0] cfg(input logic [15:0] w);
    return {1'b0, w[10:7], w[10] | w[3], w[4], w[6], w[5]};
  endfunction

  // send a word through the host; note the config first, the event comes late
  task automatic send(input logic [15:0] w);
    logic [31:0] q;
    int n;
    if (w[15:13] == SFC_ADDR_CTRL) cur = cfg(w);
    expq.push_back(cur);
    apb(1'b1, SFC_REG_TX, {16'h0000, w}, q);
    n = 0;
    do begin
      apb(1'b0, SFC_REG_STAT, 32'h0000_0000, q);
      n++;
    end while (q[0] !== 1'b0 && n < 500);
    if (q[0] !== 1'b0) err_total++;
    repeat (8) @(posedge pclk);
  endtask

  // raw frame of nb bits on the second link, same timing as the host
  task automatic raw(input int nb, input logic [23:0] d);
    for (int i = nb - 1; i >= 0; i--) begin
      l2.sdin <= d[i];
      l2.sync_n <= 1'b0;
      repeat (4) @(posedge pclk);
      l2.sclk <= 1'b0;
      repeat (4) @(posedge pclk);
      l2.sclk <= 1'b1;
    end
    repeat (4) @(posedge pclk);
    l2.sync_n <= 1'b1;
    l2.sdin <= ~d[0];  // released line shows the inverse of its last bit
    repeat (20) @(posedge pclk);
  endtask

  // event counters of the second device
  always @(posedge pclk) begin
    if (fail2 === 1'b1) n_fail2++;
    if (done2 === 1'b1) n_done2++;
  end

  // watcher: config outputs settle one edge after the event pulse, so compare then
  always @(posedge pclk) begin
    if (ev_d) begin
      if (expq.size() == 0) chk("unexpected event", 16'h0000, 16'h0001);
      else chk("config", {7'h00, expq.pop_front()},
               {7'h00, fail_d, rng1, ovr1, sns1, clr1, oen1});
    end
    ev_d <= (done1 === 1'b1) || (fail1 === 1'b1);
    fail_d <= fail1;
  end

  initial begin
    logic [31:0] q, r;
    logic [15:0] w;
    l2.sclk = 1'b1;
    l2.sync_n = 1'b1;
    l2.sdin = 1'b0;
    r = $urandom(32'h7a25);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    range_pins <= r[3:0];
    sense_pin <= r[4];
    repeat (3) @(posedge pclk);
    chk("irq after reset", 16'h0000, {15'h0000, irq});
    for (int k = 0; k < 16; k++) begin
      r = $urandom;
      send({5'h00, k[3:0], r[3:0], 3'h0});
    end
    $display("test range_codes done");
    apb(1'b0, SFC_REG_IRQ, 32'h0000_0000, q);
    chk("irq done bit", 16'h0001, {15'h0000, q[0]});
    chk("irq masked", 16'h0000, {15'h0000, irq});
    apb(1'b1, SFC_REG_MASK, 32'h0000_0003, q);
    chk("irq raised", 16'h0001, {15'h0000, irq});
    apb(1'b1, SFC_REG_IRQ, 32'h0000_0001, q);
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    $display("test interrupt done");
    apb(1'b1, SFC_REG_CTRL, 32'h0000_0001, q);
    repeat (4) begin
      r = $urandom;
      send({5'h00, r[7:0], 3'h0});
    end
    $display("test crc_frames done");
    r = $urandom;
    flt <= r[2:0] | 3'h4;
    repeat (10) @(posedge pclk);
    chk("fault wire", 16'h0000, {15'h0000, l1.fault_i});
    apb(1'b0, SFC_REG_STAT, 32'h0000_0000, q);
    chk("stat fault", 16'h0002, {14'h0000, q[1:0]});
    chk("irq fault", 16'h0001, {15'h0000, irq});
    // plain 16-bit frames, so the whole readback word lands in the capture
    apb(1'b1, SFC_REG_CTRL, 32'h0000_0000, q);
    send(16'h2000);
    send(16'he000);
    apb(1'b0, SFC_REG_RX, 32'h0000_0000, q);
    chk("status word", {5'b00110, cur[7:4], cur[1], cur[0], cur[2], 1'b0, r[2:0] | 3'h4}, q[15:0]);
    flt <= 3'h0;
    repeat (10) @(posedge pclk);
    chk("fault gone", 16'h0001, {15'h0000, l1.fault_i});
    hw_mode <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("pin config", {7'h00, 1'b0, range_pins, range_pins[3], sense_pin, 2'b01},
        {7'h00, 1'b0, rng1, ovr1, sns1, clr1, oen1});
    hw_mode <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, 8'h20, 32'h0000_0000, q);
    chk("unmapped data", 16'h0000, q[15:0]);
    chk("unmapped err", 16'h0001, {15'h0000, last_err});
    $display("test status_fault done");
    r = $urandom;
    w = {5'h00, r[7:0], 3'h0};
    raw(24, {w, crc8(w)});
    chk("good frame", 16'h0001, n_done2[15:0]);
    chk("good range", {12'h000, w[10:7]}, {12'h000, rng2});
    raw(24, {w ^ 16'h0780, ~crc8(w ^ 16'h0780)});
    chk("crc fails", 16'h0001, n_fail2[15:0]);
    chk("range kept", {12'h000, w[10:7]}, {12'h000, rng2});
    chk("fault pulled", 16'h0000, {15'h0000, l2.fault_i});
    raw(20, {4'h0, w ^ 16'h0780, 4'h0});
    chk("short ignored", 16'h0001, n_done2[15:0]);
    chk("short range", {12'h000, w[10:7]}, {12'h000, rng2});
    raw(16, {8'h00, 16'h2000});
    chk("fault freed", 16'h0001, {15'h0000, l2.fault_i});
    chk("read done", 16'h0002, n_done2[15:0]);
    chk("notes left", 16'h0000, 16'(expq.size()));
    $display("test raw_link done");
    print_verdict();
  end

  // watchdog: far beyond the expected length of the run
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    print_verdict();
  end
endmodule // tb

//--- logic/sfc_dev.sv
// device end: frame receiver, crc checker, control and status, fault pin
//
// What this block does
// - host appends crc-8 poly x8+x2+x+1
// - host shifts 24 bits before raising sync
// - 24-bit frame checked at sync rise
// - matching crc commits data to addressed register
// - crc failure discards write, flags, pulls fault
// - status read clears crc flag, releases fault
// - 16-bit words, sampled on falling sclk
// - host drives clock, data and low sync
// - overrange mode from range code, register or pins
// - sense resistor select from shift register bit, or from the sense pin in hardware mode
// - status low bits: crc, temp, iopen, vshort
// - fault pin low on any fault
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/10ps
module sfc_dev
  import sfc_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // serial link
  sfc_link_if.dev         link,
  // mode straps and pins, from outside the clock domain
  input  wire logic       hw_mode,
  input  wire logic [3:0] range_pins,
  input  wire logic       sense_pin,
  // analog fault detectors, from outside the clock domain
  input  wire logic       over_temp,
  input  wire logic       iout_open,
  input  wire logic       vout_short,
  // configuration towards the output stage
  output logic      [3:0] range_code,
  output logic            overrange_en,
  output logic            sense_res_select,
  output logic            clear_sel,
  output logic            out_enable,
  // events
  output logic            crc_fail,
  output logic            frame_done
);

  // two-stage synchronisers for every outside input
  logic [9:0] meta;      // first stage, read only by the second
  logic [9:0] sync_q;    // second stage, safe to use
  logic       sclk_d;    // previous synced link clock
  logic       sync_d;    // previous synced frame sync

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // link and strap bits reset to their idle high level; the temperature
      // flag resets inactive so the fault wire stays released during reset
      meta   <= 10'h3FE;
      sync_q <= 10'h3FE;
    end else begin
      meta   <= {link.sclk, link.sdin, link.sync_n, hw_mode, range_pins,
                 sense_pin, over_temp};
      sync_q <= meta;
    end
  end

  // the remaining two fault flags get their own pair of stages
  logic [1:0] fmeta;     // first stage
  logic [1:0] fsync;     // second stage

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmeta <= 2'h0;
      fsync <= 2'h0;
    end else begin
      fmeta <= {iout_open, vout_short};
      fsync <= fmeta;
    end
  end

  // named views of the synced inputs
  logic       s_sclk;
  logic       s_sdin;
  logic       s_sync_n;
  logic       s_hw;
  logic [3:0] s_range;
  logic       s_sense;
  logic       s_temp;
  assign s_sclk   = sync_q[9];
  assign s_sdin   = sync_q[8];
  assign s_sync_n = sync_q[7];
  assign s_hw     = sync_q[6];
  assign s_range  = sync_q[5:2];
  assign s_sense  = sync_q[1];
  assign s_temp   = sync_q[0];

  // edge history of link clock and sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d <= 1'b1;
      sync_d <= 1'b1;
    end else begin
      sclk_d <= s_sclk;
      sync_d <= s_sync_n;
    end
  end

  logic sclk_fall;   // two pclk after a falling link clock edge inside a frame
  logic sync_fall;   // frame start
  logic sync_rise;   // frame end, where the frame is judged
  assign sclk_fall = sclk_d & ~s_sclk & ~s_sync_n;
  assign sync_fall = sync_d & ~s_sync_n;
  assign sync_rise = ~sync_d & s_sync_n;

  // input shift register and bit count
  logic [23:0] in_sr;    // last 24 bits received
  logic [4:0]  bit_cnt;  // saturates so long frames never wrap to 16 or 24
  logic [7:0]  crc;      // crc over the first 16 bits

  // sample data on falling link clock, msb first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_sr   <= 24'h00_0000;
      bit_cnt <= 5'h00;
      crc     <= SFC_CRC_INIT;
    end else if (sync_fall) begin
      bit_cnt <= 5'h00;
      crc     <= SFC_CRC_INIT;
    end else if (sclk_fall) begin
      in_sr <= {in_sr[22:0], s_sdin};
      if (bit_cnt != 5'h1F) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
      // only the data word feeds the checker; the trailing byte is the check value
      if (bit_cnt < 5'(SFC_WORD_BITS)) begin
        crc <= sfc_crc_step(crc, s_sdin);
      end
    end
  end

  // frame judgement at sync rise
  logic        len16;     // plain word, no check
  logic        len24;     // word with check byte
  logic [15:0] rx_word;   // data part of the frame
  logic        crc_ok;    // received byte equals computed one
  logic        commit;    // frame is good and is applied
  logic        bad_crc;   // 24-bit frame failed the check
  assign len16   = (bit_cnt == 5'(SFC_WORD_BITS));
  assign len24   = (bit_cnt == 5'(SFC_FRAME_BITS));
  assign rx_word = len24 ? in_sr[23:8] : in_sr[15:0];
  assign crc_ok  = (in_sr[7:0] == crc);
  assign commit  = sync_rise & (len16 | (len24 & crc_ok));
  assign bad_crc = sync_rise & len24 & ~crc_ok;

  logic is_ctrl;   // write to the control register
  logic is_read;   // status readback request
  assign is_ctrl = commit & (rx_word[SFC_ADDR_MSB:SFC_ADDR_LSB] == SFC_ADDR_CTRL);
  assign is_read = commit & (rx_word[SFC_ADDR_MSB:SFC_ADDR_LSB] == SFC_ADDR_READ);

  // control register; written only by a good frame
  logic [3:0] reg_range;   // range code bits
  logic       reg_clrsel;  // clear select bit
  logic       reg_outen;   // output enable bit
  logic       reg_rsel;    // external sense resistor bit
  logic       reg_over;    // overrange request bit

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_range  <= SFC_RANGE_RST;
      reg_clrsel <= 1'b0;
      reg_outen  <= 1'b0;
      reg_rsel   <= 1'b0;
      reg_over   <= 1'b0;
    end else if (is_ctrl) begin
      // a failed frame never reaches here, so the write is discarded
      reg_range  <= rx_word[SFC_RANGE_MSB:SFC_RANGE_LSB];
      reg_clrsel <= rx_word[SFC_CLRSEL_BIT];
      reg_outen  <= rx_word[SFC_OUTEN_BIT];
      reg_rsel   <= rx_word[SFC_RSEL_BIT];
      reg_over   <= rx_word[SFC_OVER_BIT];
    end
  end

  // crc error flag: set at a failed check, cleared by a status read
  logic crc_err;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_err <= 1'b0;
    end else if (bad_crc) begin
      crc_err <= 1'b1;
    end else if (is_read) begin
      crc_err <= 1'b0;
    end
  end

  // status word, low four bits carry the fault flags
  logic [15:0] status;
  assign status = {SFC_ADDR_READ, SFC_STAT_MARK, range_code, clear_sel, out_enable,
                   sense_res_select, crc_err, s_temp, fsync[1], fsync[0]};

  // readback shifter: loaded by a read, shifted after each sampled falling edge
  logic [15:0] out_sr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_sr <= SFC_WORD_RST;
    end else if (is_read) begin
      // the flag is read out as set, then cleared in the same cycle
      out_sr <= status;
    end else if (sclk_fall) begin
      out_sr <= {out_sr[14:0], 1'b0};
    end
  end
  assign link.sdo = out_sr[15];

  // any fault pulls the open-drain wire low
  logic any_fault;
  assign any_fault     = crc_err | s_temp | fsync[1] | fsync[0];
  assign link.fault_o  = 1'b0;
  assign link.fault_oe = any_fault;

  // configuration outputs: range, overrange and sense from pins in hardware mode, register otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_code       <= SFC_RANGE_RST;
      overrange_en     <= 1'b0;
      sense_res_select <= 1'b0;
      clear_sel        <= 1'b0;
      out_enable       <= 1'b0;
    end else begin
      range_code       <= s_hw ? s_range : reg_range;
      // overrange follows the top bit of the range code, in register mode also the overrange bit
      overrange_en     <= s_hw ? s_range[3] : (reg_range[3] | reg_over);
      sense_res_select <= s_hw ? s_sense : reg_rsel;
      clear_sel        <= ~s_hw & reg_clrsel;
      out_enable       <= s_hw | reg_outen;
    end
  end

  // event pulses for the surrounding logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_fail   <= 1'b0;
      frame_done <= 1'b0;
    end else begin
      crc_fail   <= bad_crc;
      frame_done <= commit;
    end
  end

endmodule // sfc_dev

//--- logic/sfc_host.sv
// host end: apb-controlled frame sender with crc generation and readback capture
`timescale 1ns/10ps
module sfc_host
  import sfc_pkg::*;
#(
  parameter int unsigned HALF_CYC = SFC_HALF_CYC  // pclk cycles per link clock half
)(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt
  output logic             irq,
  // serial link
  sfc_link_if.host         link
);

  typedef enum logic [3:0] {
    SH_IDLE  = 4'b0001,
    SH_LEAD  = 4'b0010,
    SH_SHIFT = 4'b0100,
    SH_TAIL  = 4'b1000
  } sfc_hstate_t;

  sfc_hstate_t state;
  logic [15:0] half_cnt;   // divider towards one half link period
  logic        tick;       // one-cycle enable at each half period
  logic [23:0] tx_sr;      // bits still to send, msb first
  logic [4:0]  left;       // bits still to send
  logic [15:0] rx_sr;      // readback capture
  logic        crc_en;     // append check byte
  logic [15:0] rx_word;    // last captured readback word
  logic [1:0]  irq_stat;   // sticky events
  logic [1:0]  irq_mask;   // enables
  logic [1:0]  fmeta;      // fault wire and sdo, first stage
  logic [1:0]  fsync;      // second stage
  logic        fault_d;    // previous fault level

  // apb decode, zero wait state
  logic wr;
  logic rd_ok;
  logic start;
  logic busy;
  assign wr      = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign rd_ok   = (paddr == SFC_REG_TX) | (paddr == SFC_REG_CTRL) |
                   (paddr == SFC_REG_STAT) | (paddr == SFC_REG_RX) |
                   (paddr == SFC_REG_IRQ) | (paddr == SFC_REG_MASK);
  assign pslverr = psel & penable & ~rd_ok;
  assign busy    = (state != SH_IDLE);
  // a word written while busy is dropped; software polls busy first
  assign start   = wr & (paddr == SFC_REG_TX) & ~busy;

  // read mux
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      SFC_REG_CTRL: prdata = {31'h0000_0000, crc_en};
      SFC_REG_STAT: prdata = {30'h0000_0000, ~fsync[1], busy};
      SFC_REG_RX:   prdata = {16'h0000, rx_word};
      SFC_REG_IRQ:  prdata = {30'h0000_0000, irq_stat};
      SFC_REG_MASK: prdata = {30'h0000_0000, irq_mask};
      default:      prdata = 32'h0000_0000;
    endcase
  end

  // control and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_en   <= 1'b0;
      irq_mask <= 2'h0;
    end else if (wr && paddr == SFC_REG_CTRL) begin
      crc_en <= pwdata[0];
    end else if (wr && paddr == SFC_REG_MASK) begin
      irq_mask <= pwdata[1:0];
    end
  end

  // synchronise readback and fault wire
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmeta   <= 2'h3;
      fsync   <= 2'h3;
      fault_d <= 1'b1;
    end else begin
      fmeta   <= {link.fault_i, link.sdo};
      fsync   <= fmeta;
      fault_d <= fsync[1];
    end
  end

  // sticky events, write one to clear; a new event wins over the clear
  logic done_ev;
  logic fault_ev;
  assign fault_ev = fault_d & ~fsync[1];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == SFC_IRQ_DONE && done_ev) || (i == SFC_IRQ_FAULT && fault_ev)) begin
          irq_stat[i] <= 1'b1;
        end else if (wr && paddr == SFC_REG_IRQ && pwdata[i]) begin
          irq_stat[i] <= 1'b0;
        end
      end
    end
  end
  assign irq = |(irq_stat & irq_mask);

  // half period divider, runs only during a frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt <= 16'h0000;
    end else if (!busy || tick) begin
      half_cnt <= 16'h0000;
    end else begin
      half_cnt <= half_cnt + 16'h0001;
    end
  end
  assign tick = busy & (half_cnt == 16'(HALF_CYC - 1));

  // check byte over a whole command word, msb first from the zero start value
  function automatic logic [7:0] sfc_crc_word(input logic [15:0] w);
    logic [7:0] c;
    c = SFC_CRC_INIT;
    for (int b = 15; b >= 0; b--) begin
      c = sfc_crc_step(c, w[b]);
    end
    return c;
  endfunction

  // frame sequencer: sync low, 16 or 24 clocks, sync high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= SH_IDLE;
      tx_sr     <= 24'h00_0000;
      left      <= 5'h00;
      rx_sr     <= SFC_WORD_RST;
      rx_word   <= SFC_WORD_RST;
      link.sclk   <= 1'b1;
      link.sdin   <= 1'b0;
      link.sync_n <= 1'b1;
      done_ev   <= 1'b0;
    end else begin
      done_ev <= 1'b0;
      case (state)
        SH_IDLE: begin
          if (start) begin
            // check byte computed over the whole word up front, msb first
            tx_sr       <= crc_en ? {pwdata[15:0], sfc_crc_word(pwdata[15:0])} :
                                    {pwdata[15:0], 8'h00};
            left        <= crc_en ? 5'(SFC_FRAME_BITS) : 5'(SFC_WORD_BITS);
            link.sync_n <= 1'b0;
            link.sdin   <= pwdata[15];
            state       <= SH_LEAD;
          end
        end
        SH_LEAD: if (tick) begin
          link.sclk <= 1'b0;
          rx_sr     <= {rx_sr[14:0], fsync[0]};
          state     <= SH_SHIFT;
        end
        SH_SHIFT: if (tick) begin
          if (link.sclk) begin
            // falling edge: device takes the bit, we take readback
            link.sclk <= 1'b0;
            rx_sr     <= {rx_sr[14:0], fsync[0]};
          end else begin
            link.sclk <= 1'b1;
            tx_sr     <= {tx_sr[22:0], 1'b0};
            link.sdin <= tx_sr[22];
            left      <= left - 5'h01;
            if (left == 5'h01) begin
              state <= SH_TAIL;
            end
          end
        end
        SH_TAIL: if (tick) begin
          link.sync_n <= 1'b1;
          rx_word     <= rx_sr;
          done_ev     <= 1'b1;
          state       <= SH_IDLE;
        end
        default: state <= SH_IDLE;
      endcase
    end
  end

endmodule // sfc_host

//--- logic/sfc_link_if.sv
// three wire serial link plus readback line and open-drain fault line
`timescale 1ns/10ps
interface sfc_link_if;
  logic sclk;      // link clock, made by the host, idles high
  logic sdin;      // data toward the device
  logic sync_n;    // frame sync, active low
  logic sdo;       // readback data toward the host
  logic fault_o;   // device drive value for the fault wire (always low)
  logic fault_oe;  // device pulls the fault wire low while high
  logic fault_i;   // resolved fault wire level, made by the bench

  modport dev (input sclk, input sdin, input sync_n, output sdo,
               output fault_o, output fault_oe, input fault_i);
  modport host (output sclk, output sdin, output sync_n, input sdo, input fault_i);
endinterface

//--- logic/sfc_pkg.sv
// shared constants and types of the serial frame crc link
package sfc_pkg;
  // frame lengths in link clock bits
  localparam int unsigned SFC_WORD_BITS  = 16;
  localparam int unsigned SFC_FRAME_BITS = 24;
  localparam int unsigned SFC_CRC_BITS   = 8;
  // crc generator x^8 + x^2 + x + 1 without the top term, register starts at zero
  localparam logic [7:0]  SFC_CRC_POLY   = 8'h07;
  localparam logic [7:0]  SFC_CRC_INIT   = 8'h00;
  // command word layout: address in the top three bits
  localparam int unsigned SFC_ADDR_MSB   = 15;
  localparam int unsigned SFC_ADDR_LSB   = 13;
  localparam logic [2:0]  SFC_ADDR_CTRL  = 3'h0;
  localparam logic [2:0]  SFC_ADDR_READ  = 3'h1;
  localparam logic [2:0]  SFC_ADDR_NOP   = 3'h7;
  // control word field positions
  localparam int unsigned SFC_RANGE_MSB  = 10;
  localparam int unsigned SFC_RANGE_LSB  = 7;
  localparam int unsigned SFC_CLRSEL_BIT = 6;
  localparam int unsigned SFC_OUTEN_BIT  = 5;
  localparam int unsigned SFC_RSEL_BIT   = 4;
  localparam int unsigned SFC_OVER_BIT   = 3;
  // fixed marker bits of the status readback word
  localparam logic [1:0]  SFC_STAT_MARK  = 2'h2;
  // reset values
  localparam logic [3:0]  SFC_RANGE_RST  = 4'h0;
  localparam logic [15:0] SFC_WORD_RST   = 16'h0000;
  // host link clock: half period in pclk cycles (10 MHz pclk, 800 ns link period)
  localparam int unsigned SFC_PCLK_NS    = 100;
  localparam int unsigned SFC_LINK_NS    = 800;
  localparam int unsigned SFC_HALF_CYC   = SFC_LINK_NS / (2 * SFC_PCLK_NS);
  // host apb register byte offsets
  localparam logic [7:0]  SFC_REG_TX     = 8'h00;
  localparam logic [7:0]  SFC_REG_CTRL   = 8'h04;
  localparam logic [7:0]  SFC_REG_STAT   = 8'h08;
  localparam logic [7:0]  SFC_REG_RX     = 8'h0C;
  localparam logic [7:0]  SFC_REG_IRQ    = 8'h10;
  localparam logic [7:0]  SFC_REG_MASK   = 8'h14;
  // host irq bit positions
  localparam int unsigned SFC_IRQ_DONE   = 0;
  localparam int unsigned SFC_IRQ_FAULT  = 1;

  // one step of the serial crc, msb first
  function automatic logic [7:0] sfc_crc_step(input logic [7:0] crc, input logic bit_in);
    logic fb;
    fb = crc[7] ^ bit_in;
    return {crc[6:0], 1'b0} ^ (fb ? SFC_CRC_POLY : 8'h00);
  endfunction
endpackage
